// >>> design/stp_consts.vh
// Constants for the staggered time-proportional output sequencer
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH
`define STP_NCH 8
`define STP_CH_W 3
`define STP_DUTY_W 10
`define STP_DUTY_FULL 10'h3e8
`define STP_TIME_W 16
`define STP_ROLE_MASTER 1'h0
`define STP_ROLE_SLAVE 1'h1
`define STP_ENA_USED 1'h1
`define STP_TICK_NS 1000000
`define STP_CLK_NS 25
`define STP_TICK_CYC (`STP_TICK_NS / `STP_CLK_NS)
`define STP_TICK_CW 16
`endif

// >>> design/stp_ontime.v
// Converts a duty request into an on-time in ticks, with minimum on/off
module stp_ontime #(
    parameter DUTY_W = 10,
    parameter TIME_W = 16
) (
    // Request
    input wire [DUTY_W-1:0] duty,
    input wire [TIME_W-1:0] cycle_len,
    input wire [TIME_W-1:0] min_time,
    // Result
    output reg [TIME_W-1:0] on_time
);
`include "stp_consts.vh"
    reg [DUTY_W+TIME_W-1:0] prod;
    reg [DUTY_W+TIME_W-1:0] quo;
    reg [TIME_W-1:0] raw;
    always @* begin
        prod = duty * cycle_len;
        quo = prod / `STP_DUTY_FULL;
        raw = quo[TIME_W-1:0];
        if (duty >= `STP_DUTY_FULL)
            raw = cycle_len;
        on_time = raw;
        if (raw < min_time)
            on_time = {TIME_W{1'b0}};
        else if (cycle_len - raw < min_time)
            on_time = cycle_len;
    end
endmodule

// >>> design/stp_seq.v
// Staggered time-proportional output sequencer, eight channels
// Operation
// - Up to eight outputs per group; one master, one or more slaves.
// - Master switches on at every cycle start, before any slave.
// - Role value 0 marks master, value 1 marks slave.
// - First slave waits until master has switched off this cycle.
// - Each later slave starts only after its predecessor switched off.
// - Per-channel enable; value 1 puts the channel into sequencing.
// - Wait the inter-channel delay after predecessor off before next on.
// - Last active slave stays off for the delay before cycle end.
// - Slave on-time cut at cycle end when the cycle runs out.
// - Sequencing overrides requested duty only for enabled channels; others run plain time-proportional.
module stp_seq #(
    parameter NCH = 8,
    parameter DUTY_W = 10,
    parameter TIME_W = 16,
    parameter TICK_CYC = 40000
) (
    // Clock and reset
    input wire MCLK,
    input wire RST,
    // Configuration: per-channel fields packed, then shared cycle timing
    input wire [NCH-1:0] STAG_ENA,
    input wire [NCH-1:0] ROLE,
    input wire [NCH*3-1:0] NEXT_CH,
    input wire [TIME_W-1:0] CYCLE_LEN,
    input wire [TIME_W-1:0] MIN_TIME,
    input wire [TIME_W-1:0] DELAY_TIME,
    // Duty requests, units of 0.1 percent
    input wire [NCH*DUTY_W-1:0] DUTY,
    // Outputs and status
    output reg [NCH-1:0] OUT_ON,
    output reg [NCH-1:0] CUT_FLAG,
    output reg CYCLE_START
);
`include "stp_consts.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_ON = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [`STP_TICK_CW-1:0] pre_r;
    reg [TIME_W-1:0] pos_r;
    reg tick;
    reg [TIME_W-1:0] on_t [0:NCH-1];
    reg [TIME_W-1:0] rem_r [0:NCH-1];
    reg [TIME_W-1:0] gap_r [0:NCH-1];
    reg [1:0] st_r [0:NCH-1];
    reg [NCH-1:0] go_r;
    wire [TIME_W-1:0] ot [0:NCH-1];
    wire cyc_end;
    integer i;
    integer j;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : conv
            stp_ontime #(.DUTY_W(DUTY_W), .TIME_W(TIME_W)) u_ot (
                .duty(DUTY[g*DUTY_W +: DUTY_W]),
                .cycle_len(CYCLE_LEN),
                .min_time(MIN_TIME),
                .on_time(ot[g])
            );
        end
    endgenerate

    function [2:0] nxt_of;
        input [NCH*3-1:0] v;
        input integer k;
        begin
            nxt_of = v[k*3 +: 3];
        end
    endfunction

    // Channel takes part in the group as a slave
    function is_slave;
        input [NCH-1:0] ena;
        input [NCH-1:0] role;
        input integer k;
        begin
            is_slave = (ena[k] == `STP_ENA_USED) && (role[k] == `STP_ROLE_SLAVE);
        end
    endfunction

    // Channel takes part in the group as its master
    function is_master;
        input [NCH-1:0] ena;
        input [NCH-1:0] role;
        input integer k;
        begin
            is_master = (ena[k] == `STP_ENA_USED) && (role[k] == `STP_ROLE_MASTER);
        end
    endfunction

    // Inside the trailing delay window ahead of the next master start
    function in_tail;
        input [TIME_W-1:0] pos;
        input [TIME_W-1:0] len;
        input [TIME_W-1:0] dly;
        begin
            in_tail = ({1'b0, pos} + {1'b0, dly}) >= {1'b0, len};
        end
    endfunction

    // End of cycle when the position reaches the cycle length
    assign cyc_end = tick && (pos_r + 16'h0001 >= CYCLE_LEN);

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pre_r <= 16'h0000;
            tick <= 1'b0;
        end else if (pre_r == TICK_CYC - 1) begin
            pre_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            pre_r <= pre_r + 16'h0001;
            tick <= 1'b0;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pos_r <= 16'h0000;
            CYCLE_START <= 1'b0;
        end else begin
            CYCLE_START <= cyc_end;
            if (cyc_end)
                pos_r <= 16'h0000;
            else if (tick)
                pos_r <= pos_r + 16'h0001;
        end
    end

    // Per-channel sequencing
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            OUT_ON <= {NCH{1'b0}};
            go_r <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                st_r[i] <= ST_IDLE;
                rem_r[i] <= 16'h0000;
                gap_r[i] <= 16'h0000;
                on_t[i] <= 16'h0000;
            end
        end else begin
            go_r <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                if (cyc_end) begin
                    // Latch request for next cycle; a slave still on is aborted
                    on_t[i] <= ot[i];
                    OUT_ON[i] <= 1'b0;
                    st_r[i] <= ST_IDLE;
                    // Master starts the next cycle ahead of all slaves
                    if (is_master(STAG_ENA, ROLE, i)) begin
                        st_r[i] <= ST_ON;
                        rem_r[i] <= ot[i];
                        OUT_ON[i] <= (ot[i] != 16'h0000);
                    end
                end else if (STAG_ENA[i] != `STP_ENA_USED) begin
                    // Non-participating channel: plain time-proportional output
                    OUT_ON[i] <= (pos_r < on_t[i]);
                end else begin
                    case (st_r[i])
                        ST_IDLE: begin
                            // Slave held until predecessor finished its gap
                            if (go_r[i] && ROLE[i] == `STP_ROLE_SLAVE) begin
                                st_r[i] <= ST_ON;
                                rem_r[i] <= on_t[i];
                                // No slave starts inside the trailing delay
                                OUT_ON[i] <= (on_t[i] != 16'h0000) &&
                                    !in_tail(pos_r, CYCLE_LEN, DELAY_TIME);
                            end
                        end
                        ST_ON: begin
                            if (rem_r[i] == 16'h0000) begin
                                OUT_ON[i] <= 1'b0;
                                gap_r[i] <= DELAY_TIME;
                                st_r[i] <= ST_GAP;
                            end else begin
                                // Tail window wins over any slave duty
                                if (is_slave(STAG_ENA, ROLE, i) &&
                                        in_tail(pos_r, CYCLE_LEN, DELAY_TIME))
                                    OUT_ON[i] <= 1'b0;
                                if (tick)
                                    rem_r[i] <= rem_r[i] - 16'h0001;
                            end
                        end
                        ST_GAP: begin
                            if (gap_r[i] == 16'h0000) begin
                                st_r[i] <= ST_DONE;
                                // Hand over to successor unless last in chain
                                if (nxt_of(NEXT_CH, i) != i[2:0])
                                    go_r[nxt_of(NEXT_CH, i)] <= 1'b1;
                            end else if (tick) begin
                                gap_r[i] <= gap_r[i] - 16'h0001;
                            end
                        end
                        ST_DONE: begin
                            OUT_ON[i] <= 1'b0;
                        end
                        default: begin
                            OUT_ON[i] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Cut marker: set for a slave still running at the wrap
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CUT_FLAG <= {NCH{1'b0}};
        end else if (cyc_end) begin
            for (j = 0; j < NCH; j = j + 1) begin
                CUT_FLAG[j] <= is_slave(STAG_ENA, ROLE, j) && (st_r[j] == ST_ON);
            end
        end
    end
endmodule

// >>> test/stp_seq_assertions.sv
// Assertion checker for the staggered output sequencer
module stp_seq_chk #(
    parameter NCH = 8,
    parameter DUTY_W = 10,
    parameter TIME_W = 16,
    parameter TICK_CYC = 4
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Configuration
    input wire logic [NCH-1:0] STAG_ENA,
    input wire logic [NCH-1:0] ROLE,
    input wire logic [TIME_W-1:0] CYCLE_LEN,
    input wire logic [TIME_W-1:0] DELAY_TIME,
    input wire logic [NCH*DUTY_W-1:0] DUTY,
    // Outputs
    input wire logic [NCH-1:0] OUT_ON,
    input wire logic [NCH-1:0] CUT_FLAG,
    input wire logic CYCLE_START
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] idle_r, cnt_r;
    logic seen_r;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Clocks with no grouped output on, and since cycle start
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            idle_r <= 32'h0;
            cnt_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            idle_r <= |(OUT_ON & STAG_ENA) ? 32'h0 : idle_r + 32'h1;
            cnt_r <= CYCLE_START ? 32'h0 : cnt_r + 32'h1;
            seen_r <= seen_r | CYCLE_START;
        end
    end
    no_overlap_a: assert property ($onehot0(OUT_ON & STAG_ENA))
        else $error("grouped outputs overlap");
    master_first_a: assert property (CYCLE_START && STAG_ENA[0] && !ROLE[0]
        && DUTY[DUTY_W-1:0] >= 100 |-> ##[0:1] OUT_ON[0]) else $error("master not on");
    slaves_off_a: assert property (CYCLE_START |-> (OUT_ON & ROLE & STAG_ENA) == 0)
        else $error("slave on at cycle start");
    slave_gap_a: assert property ($rose(|(OUT_ON & ROLE & STAG_ENA))
        |-> $past(idle_r) + 32'h1 + TICK_CYC >= DELAY_TIME * TICK_CYC) else $error("gap short");
    cycle_len_a: assert property (CYCLE_START && seen_r
        |-> cnt_r == CYCLE_LEN * TICK_CYC - 1) else $error("cycle length wrong");
    start_pulse_a: assert property (CYCLE_START |=> !CYCLE_START)
        else $error("start pulse too long");
    cut_slave_a: assert property ((CUT_FLAG & ~(ROLE & STAG_ENA)) == 0)
        else $error("cut flag on non-slave");
    cut_timing_a: assert property ($changed(CUT_FLAG)
        |-> $past(CYCLE_START) or ##[0:1] CYCLE_START) else $error("cut off cycle end");
    tail_quiet_a: assert property (seen_r && |(OUT_ON & ROLE & STAG_ENA)
        |-> cnt_r < (CYCLE_LEN - DELAY_TIME) * TICK_CYC) else $error("slave on in tail");
endmodule
bind stp_seq stp_seq_chk #(.NCH(NCH), .DUTY_W(DUTY_W), .TIME_W(TIME_W), .TICK_CYC(TICK_CYC))
    chk_u (.MCLK(MCLK), .RST(RST), .STAG_ENA(STAG_ENA), .ROLE(ROLE), .CYCLE_LEN(CYCLE_LEN),
    .DELAY_TIME(DELAY_TIME), .DUTY(DUTY), .OUT_ON(OUT_ON), .CUT_FLAG(CUT_FLAG),
    .CYCLE_START(CYCLE_START));

// >>> test/stp_act.sv
// Actuator model: counts on-clocks of each output per cycle
module stp_act (
    // Clock, reset, cycle marker
    input wire logic clk, rst, cyc,
    // Switched outputs and last cycle's on-clocks
    input wire logic [7:0] on,
    output logic [7:0][15:0] last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0][15:0] run;
    always_ff @(posedge clk or posedge rst) begin
        for (int k = 0; k < 8; k++) begin
            if (rst) begin
                run[k] <= 16'h0;
                last[k] <= 16'h0;
            end else if (cyc) begin
                last[k] <= run[k];
                run[k] <= {15'h0, on[k]};
            end else begin
                run[k] <= run[k] + {15'h0, on[k]};
            end
        end
    end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the staggered output sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TCK = 4;
    logic MCLK = 1'b0, RST = 1'b1, CYCLE_START;
    logic [7:0] STAG_ENA = 8'h0, ROLE = 8'hff, OUT_ON, CUT_FLAG;
    logic [23:0] NEXT_CH = 24'h0;
    logic [15:0] CYCLE_LEN = 16'h14, MIN_TIME = 16'h1, DELAY_TIME = 16'h2;
    logic [79:0] DUTY = 80'h0;
    logic [7:0][15:0] on_clk;
    int num_errors = 0, compares = 0, clk_n = 0;
    stp_seq #(.TICK_CYC(TCK)) dut_u (
        .MCLK(MCLK), .RST(RST), .STAG_ENA(STAG_ENA), .ROLE(ROLE), .NEXT_CH(NEXT_CH),
        .CYCLE_LEN(CYCLE_LEN), .MIN_TIME(MIN_TIME), .DELAY_TIME(DELAY_TIME), .DUTY(DUTY),
        .OUT_ON(OUT_ON), .CUT_FLAG(CUT_FLAG), .CYCLE_START(CYCLE_START)
    );
    stp_act act_u (.clk(MCLK), .rst(RST), .cyc(CYCLE_START), .on(OUT_ON), .last(on_clk));
    initial forever #12.5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        clk_n++;
        if (clk_n == 3000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_val(string nm, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    // On-clocks within one clock of the tick figure
    task automatic chk_on(int k, int t);
        logic [15:0] e;
        e = 16'(t * TCK);
        compares++;
        if ($isunknown(on_clk[k]) || on_clk[k] + 16'h1 < e || on_clk[k] > e + 16'h1) begin
            num_errors++;
            $display("[ERR] on%0d exp %0d got %0d", k, e, on_clk[k]);
        end
    endtask
    task automatic cycles(int n);
        repeat (n) @(posedge MCLK iff CYCLE_START === 1'b1);
        @(negedge MCLK);
    endtask
    initial begin
        repeat (12) @(negedge MCLK);
        RST = 1'b0;
        STAG_ENA = 8'h07;
        ROLE = 8'hfe;
        NEXT_CH = {15'h0, 3'h2, 3'h2, 3'h1};
        DUTY = {40'h0, 10'h1f4, 10'h0c8, 10'h0c8, 10'h0c8};
        cycles(3);
        chk_on(0, 4);
        chk_on(1, 4);
        chk_on(2, 4);
        chk_on(3, 10);
        chk_val("cut", 8'h00, CUT_FLAG);
        // Long master leaves the slave too little room
        DUTY = {50'h0, 10'h12c, 10'h320};
        cycles(3);
        chk_on(0, 16);
        chk_on(1, 0);
        chk_on(2, 0);
        chk_val("cut", 8'h02, CUT_FLAG);
        // Short duties again: the cut marker clears after one clean cycle
        DUTY = {40'h0, 10'h1f4, 10'h0c8, 10'h0c8, 10'h0c8};
        cycles(2);
        chk_val("cut", 8'h00, CUT_FLAG);
        chk_on(1, 4);
        finish_test();
    end
endmodule
